// File: hdl/pbc_pkg.sv
// pbc_pkg: register map, field positions and carriers for the phy base config bank
// assumes an axi4-lite master with 32-bit data, one aligned word per register
package pbc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [3:0] PBC_IDX_SPEED_DELAY = 4'h3;
  localparam logic [3:0] PBC_IDX_LINK_CFG    = 4'h4;
  localparam logic [3:0] PBC_IDX_INT_CTRL    = 4'h5;
  localparam int         PBC_ADDR_W          = 6;
  localparam logic [5:0] PBC_ADDR_SPEED_DELAY = 6'h0c;
  localparam logic [5:0] PBC_ADDR_LINK_CFG    = 6'h10;
  localparam logic [5:0] PBC_ADDR_INT_CTRL    = 6'h14;

  // ------------------------------------------------------------------
  // fixed capability values
  // ------------------------------------------------------------------
  localparam logic [2:0] PBC_SPEED_VAL  = 3'h2;
  localparam logic [3:0] PBC_DELAY_VAL  = 4'h0;
  localparam logic [2:0] PBC_JITTER_VAL = 3'h0;

  // ------------------------------------------------------------------
  // field positions within the low byte
  // ------------------------------------------------------------------
  localparam int PBC_B_LCTL   = 7;
  localparam int PBC_B_CONT   = 6;
  localparam int PBC_B_RIE    = 7;
  localparam int PBC_B_SRR    = 6;
  localparam int PBC_B_CTO    = 5;
  localparam int PBC_B_CPD    = 4;
  localparam int PBC_B_STO    = 3;
  localparam int PBC_B_PEV    = 2;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic PBC_RST_LCTL = 1'b1;
  localparam logic PBC_RST_CPD  = 1'b1;
  localparam logic PBC_RST_ZERO = 1'b0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 20000;
  localparam int SHORT_RESET_NS_X10 = 13;
  localparam int SHORT_RESET_CYC    = (SHORT_RESET_NS_X10 * 100000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
  localparam int PBC_CNT_W          = 7;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       link_active;   // self-id bit 9
    logic       contender;     // self-id bit 20
    logic [2:0] power_class;   // self-id bits 21-23
  } pbc_selfid_t;

  typedef struct packed {
    logic resume_start;        // pulse: resume begins on any port
    logic config_timeout;      // pulse: tree-id start timeout
    logic state_timeout;       // pulse: state machine timeout
    logic bus_reset;           // pulse: a bus reset happened
  } pbc_events_t;

  typedef enum logic [2:0] {
    PBC_SR_IDLE = 3'b001,
    PBC_SR_WAIT = 3'b010,
    PBC_SR_RUN  = 3'b100
  } pbc_sr_state_t;

endpackage : pbc_pkg

// File: hdl/pbc_regs.sv
// pbc_regs: link/contender/power config and interrupt/reset control bank
// assumes aresetn is the hardware reset and bus resets arrive as event pulses
//
// Behaviour
// - delay field reads fixed zero
// - self-id link bit is control AND power
// - link control sets on hardware reset only
// - link interface follows power status input only
// - contender bit copied to self-id
// - contender loaded from pin at reset
// - jitter field reads fixed zero
// - power class copied to self-id
// - power class loaded from straps at reset
// - resume enable gates port event flag
// - short reset request starts 1.3 us reset
// - short reset may become long reset
// - config timeout flag, write-one clears
// - config timeout wakes inactive link while resume enable set
// - loop nodes report config timeout only
// - cable power drop flag on falling edge
// - state timeout flag, forces bus reset
// - state timeout wakes inactive link while resume enable set
// - port event flag on resume start
`timescale 1ns/1ps
module pbc_regs (
  input  wire logic                          aclk,            // 50 mhz clock
  input  wire logic                          aresetn,         // hardware reset, low
  input  wire logic [pbc_pkg::PBC_ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire logic                          s_axi_awvalid,   // write address valid
  output logic                               s_axi_awready,   // write address ready
  input  wire logic [31:0]                   s_axi_wdata,     // write data
  input  wire logic [3:0]                    s_axi_wstrb,     // byte strobes
  input  wire logic                          s_axi_wvalid,    // write data valid
  output logic                               s_axi_wready,    // write data ready
  output logic [1:0]                         s_axi_bresp,     // write response
  output logic                               s_axi_bvalid,    // write response valid
  input  wire logic                          s_axi_bready,    // write response ready
  input  wire logic [pbc_pkg::PBC_ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire logic                          s_axi_arvalid,   // read address valid
  output logic                               s_axi_arready,   // read address ready
  output logic [31:0]                        s_axi_rdata,     // read data
  output logic [1:0]                         s_axi_rresp,     // read response
  output logic                               s_axi_rvalid,    // read valid
  input  wire logic                          s_axi_rready,    // read ready
  input  wire logic                          link_power_status_input, // link powered pin
  input  wire logic                          cable_power_status_input, // cable power pin
  input  wire logic                          contender_linkon_in,     // pin level in
  input  wire logic [2:0]                    power_class_straps,      // strap pins
  input  wire pbc_pkg::pbc_events_t          events,          // core event pulses
  input  wire logic                          short_reset_ready, // core can arbitrate now
  output pbc_pkg::pbc_selfid_t               selfid,          // self-id fields
  output logic                               link_if_enable,  // link interface on
  output logic                               short_reset_go,  // core: start short reset
  output logic                               contender_linkon_out, // link-on drive
  output logic                               contender_linkon_oe_n // low while driving
);
  import pbc_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers (three stages, change when last two agree)
  // ------------------------------------------------------------------
  logic [2:0] lnk_sync;
  logic [2:0] cbl_sync;
  logic       lnk_state;
  logic       cbl_state;
  logic       cbl_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk_sync <= 3'h0;
      cbl_sync <= 3'h0;
    end else begin
      lnk_sync <= {lnk_sync[1:0], link_power_status_input};
      cbl_sync <= {cbl_sync[1:0], cable_power_status_input};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk_state <= 1'b0;
      cbl_state <= 1'b0;
      cbl_prev  <= 1'b0;
    end else begin
      if (lnk_sync[1] == lnk_sync[2]) begin
        lnk_state <= lnk_sync[2];
      end
      if (cbl_sync[1] == cbl_sync[2]) begin
        cbl_state <= cbl_sync[2];
      end
      cbl_prev <= cbl_state;
    end
  end

  wire cbl_fall = cbl_prev & ~cbl_state;

  // ------------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------------
  // straps are caught by the first clocked edge after release, never by the reset itself
  logic strap_pending;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------------
  logic                  aw_held;
  logic                  w_held;
  logic [PBC_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic                  w_lane0;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire have_aw  = aw_held | aw_take;
  wire have_w   = w_held | w_take;
  wire wr_fire  = have_aw & have_w & ~s_axi_bvalid;
  wire [PBC_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0]           wr_data = w_held ? w_data : s_axi_wdata;
  wire                  wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];

  function automatic logic [1:0] pbc_decode(input logic [PBC_ADDR_W-1:0] addr);
    case (addr)
      PBC_ADDR_SPEED_DELAY: pbc_decode = 2'h1;
      PBC_ADDR_LINK_CFG:    pbc_decode = 2'h2;
      PBC_ADDR_INT_CTRL:    pbc_decode = 2'h3;
      default:              pbc_decode = 2'h0;
    endcase
  endfunction : pbc_decode

  wire wr_hit_cfg = wr_fire & wr_lane & (pbc_decode(wr_addr) == 2'h2);
  wire wr_hit_int = wr_fire & wr_lane & (pbc_decode(wr_addr) == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_lane0       <= 1'b0;
    end else begin
      s_axi_awready <= ~have_aw & ~wr_fire;
      s_axi_wready  <= ~have_w & ~wr_fire;
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held  <= 1'b1;
          w_data  <= s_axi_wdata;
          w_lane0 <= s_axi_wstrb[0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // unmapped addresses answer slverr
      s_axi_bresp  <= (pbc_decode(wr_addr) == 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // link / contender / power class register
  // ------------------------------------------------------------------
  logic       link_active_control;
  logic       contender;
  logic [2:0] power_class;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_active_control <= PBC_RST_LCTL;
      contender           <= PBC_RST_ZERO;
      power_class         <= 3'h0;
    end else if (strap_pending) begin
      contender   <= contender_linkon_in;
      power_class <= power_class_straps;
    end else if (wr_hit_cfg) begin
      // bus resets leave this register alone
      link_active_control <= wr_data[PBC_B_LCTL];
      contender           <= wr_data[PBC_B_CONT];
      power_class         <= wr_data[2:0];
    end
  end

  // ------------------------------------------------------------------
  // interrupt and reset control register
  // ------------------------------------------------------------------
  logic resume_interrupt_enable;
  logic short_reset_request;
  logic config_timeout_flag;
  logic cable_power_drop_flag;
  logic state_timeout_flag;
  logic port_event_flag;

  wire w1c_cto = wr_hit_int & wr_data[PBC_B_CTO];
  wire w1c_cpd = wr_hit_int & wr_data[PBC_B_CPD];
  wire w1c_sto = wr_hit_int & wr_data[PBC_B_STO];
  wire w1c_pev = wr_hit_int & wr_data[PBC_B_PEV];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_interrupt_enable <= PBC_RST_ZERO;
    end else if (wr_hit_int) begin
      resume_interrupt_enable <= wr_data[PBC_B_RIE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_timeout_flag <= PBC_RST_ZERO;
    end else if (events.config_timeout) begin
      config_timeout_flag <= 1'b1;
    end else if (w1c_cto) begin
      config_timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cable_power_drop_flag <= PBC_RST_CPD;
    end else if (cbl_fall) begin
      cable_power_drop_flag <= 1'b1;
    end else if (w1c_cpd) begin
      cable_power_drop_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_timeout_flag <= PBC_RST_ZERO;
    end else if (events.state_timeout) begin
      state_timeout_flag <= 1'b1;
    end else if (w1c_sto) begin
      state_timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_event_flag <= PBC_RST_ZERO;
    end else if (events.resume_start & resume_interrupt_enable) begin
      port_event_flag <= 1'b1;
    end else if (w1c_pev) begin
      port_event_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // short arbitrated bus reset sequencer
  // ------------------------------------------------------------------
  pbc_sr_state_t          sr_state;
  logic [PBC_CNT_W-1:0]   sr_count;
  localparam logic [PBC_CNT_W-1:0] SR_LAST = PBC_CNT_W'(SHORT_RESET_CYC - 1);

  // state timeout forces a bus reset, which also drops the request
  wire bus_reset_any = events.bus_reset | events.state_timeout;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_reset_request <= PBC_RST_ZERO;
    end else if (bus_reset_any) begin
      short_reset_request <= 1'b0;
    end else if (wr_hit_int & wr_data[PBC_B_SRR]) begin
      short_reset_request <= 1'b1;
    end
  end

  // timed short reset
  // the core may still escalate to a long reset on legacy networks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_state       <= PBC_SR_IDLE;
      sr_count       <= '0;
      short_reset_go <= 1'b0;
    end else begin
      case (sr_state)
        PBC_SR_IDLE: begin
          short_reset_go <= 1'b0;
          if (short_reset_request) begin
            sr_state <= PBC_SR_WAIT;
          end
        end
        PBC_SR_WAIT: begin
          if (!short_reset_request) begin
            sr_state <= PBC_SR_IDLE;
          end else if (short_reset_ready) begin
            sr_state       <= PBC_SR_RUN;
            sr_count       <= '0;
            short_reset_go <= 1'b1;
          end
        end
        PBC_SR_RUN: begin
          if (sr_count == SR_LAST) begin
            short_reset_go <= 1'b0;
            sr_state       <= PBC_SR_IDLE;
          end else begin
            sr_count <= sr_count + 1'b1;
          end
        end
        default: begin
          sr_state       <= PBC_SR_IDLE;
          short_reset_go <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // self-id fields, link interface and link-on request
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selfid                <= '0;
      link_if_enable        <= 1'b0;
      contender_linkon_out  <= 1'b0;
      contender_linkon_oe_n <= 1'b1;
    end else begin
      selfid.link_active <= link_active_control & lnk_state;
      selfid.contender   <= contender;
      selfid.power_class <= power_class;
      link_if_enable     <= lnk_state;
      contender_linkon_out  <= resume_interrupt_enable & ~lnk_state &
                               (config_timeout_flag | state_timeout_flag);
      contender_linkon_oe_n <= ~(resume_interrupt_enable & ~lnk_state &
                               (config_timeout_flag | state_timeout_flag));
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h0;
    case (pbc_decode(s_axi_araddr))
      2'h1: rd_byte = {PBC_SPEED_VAL, 1'b0, PBC_DELAY_VAL};
      2'h2: rd_byte = {link_active_control, contender, PBC_JITTER_VAL, power_class};
      2'h3: rd_byte = {resume_interrupt_enable, short_reset_request, config_timeout_flag,
                       cable_power_drop_flag, state_timeout_flag, port_event_flag, 2'h0};
      default: rd_byte = 8'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h0, rd_byte};
        s_axi_rresp  <= (pbc_decode(s_axi_araddr) == 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : pbc_regs

// File: tb/pbc_link_model.sv
// pbc_link_model: link controller side of the bank, an axi4-lite master
// assumes its tasks are entered just after a rising edge of aclk
`timescale 1ns/1ps
module pbc_link_model (
  input  wire logic        aclk,          // clock
  output logic [5:0]       s_axi_awaddr,  // write address
  output logic             s_axi_awvalid, // aw valid
  input  wire logic        s_axi_awready, // aw ready
  output logic [31:0]      s_axi_wdata,   // write data
  output logic [3:0]       s_axi_wstrb,   // strobes
  output logic             s_axi_wvalid,  // w valid
  input  wire logic        s_axi_wready,  // w ready
  input  wire logic [1:0]  s_axi_bresp,   // write response
  input  wire logic        s_axi_bvalid,  // b valid
  output logic             s_axi_bready,  // b ready
  output logic [5:0]       s_axi_araddr,  // read address
  output logic             s_axi_arvalid, // ar valid
  input  wire logic        s_axi_arready, // ar ready
  input  wire logic [31:0] s_axi_rdata,   // read data
  input  wire logic [1:0]  s_axi_rresp,   // read response
  input  wire logic        s_axi_rvalid,  // r valid
  output logic             s_axi_rready   // r ready
);
  // cycles before a response ready rises, so slow takers are tried too
  int stall = 0;
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
           s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;

  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    int   n;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      if (n == stall) s_axi_bready <= 1'b1;
      n++;
      @(posedge aclk);
    end while (!(s_axi_bready && s_axi_bvalid));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      if (n == stall) s_axi_rready <= 1'b1;
      n++;
      @(posedge aclk);
    end while (!(s_axi_rready && s_axi_rvalid));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : pbc_link_model

// File: tb/pbc_regs_props.sv
// pbc_regs_props: port assertions for the phy base config bank
// assumes one clock, aresetn synchronous active low; bound after the module
`timescale 1ns/1ps
module pbc_regs_props (
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready, link_if_enable,
  input wire logic short_reset_ready, short_reset_go, contender_linkon_out,
  input wire logic contender_linkon_oe_n,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire pbc_pkg::pbc_selfid_t selfid
);
  import pbc_pkg::*;
  logic [7:0] go_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the current short reset pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !short_reset_go) go_cnt <= 8'h00;
    else go_cnt <= go_cnt + 8'h01;
  end
  chk_go_length:
    assert property ($fell(short_reset_go) |-> go_cnt == 8'(SHORT_RESET_CYC))
    else $error("short reset pulse length wrong");
  chk_go_waits_ready:
    assert property ($rose(short_reset_go) |->
                     $past(short_reset_ready) || $past(short_reset_ready, 2))
    else $error("short reset started without core ready");
  chk_link_bit_gated:
    assert property (!link_if_enable [*2] |-> !selfid.link_active)
    else $error("self-id link bit set while link unpowered");
  chk_linkon_pair:
    assert property (contender_linkon_oe_n != contender_linkon_out)
    else $error("link-on enable disagrees with drive");
  chk_linkon_idle:
    assert property (link_if_enable [*3] |-> !contender_linkon_out)
    else $error("link-on driven while link active");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> s_axi_bvalid)
    else $error("write answer late");
  chk_write_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  chk_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  cov_short_reset: cover property ($fell(short_reset_go));
  cov_linkon: cover property (contender_linkon_out);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
endmodule : pbc_regs_props

bind pbc_regs pbc_regs_props u_props (.*);

// File: tb/testbench.sv
// testbench: random and corner checks of pbc_regs through the link model
// assumes pbc_pkg, the design and the checker bind are compiled first
`timescale 1ns/1ps
module testbench;
  import pbc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic link_power_status_input = 1'b1;
  logic cable_power_status_input = 1'b1;
  logic contender_linkon_in = 1'b0;
  logic short_reset_ready = 1'b0;
  logic [2:0] power_class_straps = 3'h0;
  pbc_events_t events = '0;
  pbc_selfid_t selfid;
  logic link_if_enable, short_reset_go, contender_linkon_out, contender_linkon_oe_n;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 67837;

  pbc_regs dut (.*);
  pbc_link_model link (.*);

  always #10 aclk = ~aclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    link.rd(a, d, r);
    chk(what, d, {24'h0, e});
    chk("read resp", {30'h0, r}, 32'h0);
  endtask : rdc

  task automatic wrc(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    link.wr(a, d, r);
    chk("write resp", {30'h0, r}, 32'h0);
  endtask : wrc

  task automatic pulse(input logic [3:0] e);
    events <= pbc_events_t'(e);
    step(1);
    events <= '0;
    step(1);
  endtask : pulse

  task automatic hw_reset;
    aresetn <= 1'b0;
    step(10);
    aresetn <= 1'b1;
    step(4);
  endtask : hw_reset

  // read-only jitter bits always zero, writable bits kept
  function automatic logic [7:0] cfg_exp(input logic [7:0] w);
    return {w[7:6], 3'b000, w[2:0]};
  endfunction : cfg_exp

  initial begin
    logic [7:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    power_class_straps <= 3'($random(seed));
    contender_linkon_in <= 1'b1;
    hw_reset();
    rdc(PBC_ADDR_SPEED_DELAY, {PBC_SPEED_VAL, 1'b0, PBC_DELAY_VAL}, "delay");
    rdc(PBC_ADDR_LINK_CFG, {2'b11, 3'b000, power_class_straps}, "cfg rst");
    rdc(PBC_ADDR_INT_CTRL, 8'h10, "int rst");
    chk("selfid rst", {27'h0, selfid}, {27'h0, 2'b11, power_class_straps});
    link.rd(6'h20, d, r);
    chk("unmapped", d, 32'h0);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h3d : 8'($random(seed));
      link.stall = i % 3;
      link_power_status_input <= (i == 0) ? 1'b1 : 1'($random(seed));
      wrc(PBC_ADDR_LINK_CFG, v);
      wrc(PBC_ADDR_SPEED_DELAY, ~v);
      step(6);
      rdc(PBC_ADDR_LINK_CFG, cfg_exp(v), "cfg");
      rdc(PBC_ADDR_SPEED_DELAY, 8'h40, "delay ro");
      chk("link en", {31'h0, link_if_enable}, {31'h0, link_power_status_input});
      chk("selfid", {27'h0, selfid},
          {27'h0, v[7] & link_power_status_input, v[6], v[2:0]});
    end
    $display("test config fields done");
    link_power_status_input <= 1'b1;
    wrc(PBC_ADDR_LINK_CFG, 8'h4a);
    wrc(PBC_ADDR_INT_CTRL, 8'hc0);
    pulse(4'b0001);
    rdc(PBC_ADDR_LINK_CFG, cfg_exp(8'h4a), "cfg bus rst");
    rdc(PBC_ADDR_INT_CTRL, 8'h90, "int bus rst");
    power_class_straps <= ~power_class_straps;
    contender_linkon_in <= 1'b0;
    hw_reset();
    rdc(PBC_ADDR_LINK_CFG, {2'b10, 3'b000, power_class_straps}, "cfg hw rst");
    rdc(PBC_ADDR_INT_CTRL, 8'h10, "enable hw rst");
    $display("test resets done");
    wrc(PBC_ADDR_INT_CTRL, 8'h10);
    rdc(PBC_ADDR_INT_CTRL, 8'h00, "cable clear");
    cable_power_status_input <= 1'b0;
    step(8);
    rdc(PBC_ADDR_INT_CTRL, 8'h10, "cable drop");
    cable_power_status_input <= 1'b1;
    wrc(PBC_ADDR_INT_CTRL, 8'h10);
    pulse(4'b1000);
    rdc(PBC_ADDR_INT_CTRL, 8'h00, "resume off");
    wrc(PBC_ADDR_INT_CTRL, 8'h80);
    pulse(4'b1000);
    rdc(PBC_ADDR_INT_CTRL, 8'h84, "resume on");
    wrc(PBC_ADDR_INT_CTRL, 8'h84);
    link_power_status_input <= 1'b0;
    step(8);
    // config timeout then state timeout, each waking the unpowered link
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'ha0 : 8'h88;
      pulse((k == 0) ? 4'b0100 : 4'b0010);
      step(3);
      rdc(PBC_ADDR_INT_CTRL, v, "timeout flag");
      chk("link-on", {31'h0, contender_linkon_out}, 32'h1);
      wrc(PBC_ADDR_INT_CTRL, v);
      step(3);
      rdc(PBC_ADDR_INT_CTRL, 8'h80, "timeout clear");
      chk("link-on off", {31'h0, contender_linkon_out}, 32'h0);
    end
    link_power_status_input <= 1'b1;
    $display("test flags done");
    wrc(PBC_ADDR_INT_CTRL, 8'h40);
    rdc(PBC_ADDR_INT_CTRL, 8'h40, "request");
    step(20);
    chk("go waits", {31'h0, short_reset_go}, 32'h0);
    short_reset_ready <= 1'b1;
    n = 0;
    while (short_reset_go !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    n = 0;
    while (short_reset_go === 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    short_reset_ready <= 1'b0;
    chk("go length", n, SHORT_RESET_CYC);
    pulse(4'b0001);
    rdc(PBC_ADDR_INT_CTRL, 8'h00, "request cleared");
    $display("test short reset done");
    report_and_stop();
  end
endmodule : testbench
